// ---- hdl/scd_buf.sv ----
// Two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module scd_buf
  import scd_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic srst, // Sync reset
  input wire logic in_valid, // Byte offered
  output logic in_ready, // Room available
  input wire logic [7:0] in_data, // Byte in
  output logic out_valid, // Byte waiting
  input wire logic out_ready, // Drain accepts
  output logic [7:0] out_data // Oldest byte
);
  // ==========================================================
  // Storage
  logic [7:0] mem_q [SCD_BUF_DEPTH];
  logic [7:0] mem_d [SCD_BUF_DEPTH];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  // Honest full and empty flags
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointers and contents
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // Register state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mem_q <= '{default: 8'h00};
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : scd_buf

// ---- hdl/scd_pkg.sv ----
// Shared constants for the serial clock, data and timing port
package scd_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] SCD_ADDR_DIVIDER = 8'ha2;
  localparam logic [7:0] SCD_ADDR_DATA = 8'ha3;
  localparam logic [7:0] SCD_DIVIDER_RESET = 8'h00;
  localparam logic [7:0] SCD_DATA_RESET = 8'h00;
  // ==========================================================
  // Frame and timing
  localparam int SCD_BITS = 8;
  localparam logic [2:0] SCD_LAST_BIT = 3'h7;
  localparam int SYS_PERIOD_NS = 50;
  // Slave select fall to output valid, longest time
  localparam int SLV_OUT_VALID_NS = 200;
  localparam int SLV_OUT_VALID_CYC =
    (SLV_OUT_VALID_NS / SYS_PERIOD_NS) < 1 ? 1 : SLV_OUT_VALID_NS / SYS_PERIOD_NS;
  // Last edge to output change with phase 1, least time
  localparam int SLV_LAST_HOLD_NS = 300;
  localparam int SLV_LAST_HOLD_CYC = (SLV_LAST_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [3:0] SLV_LAST_HOLD_CNT = 4'(SLV_LAST_HOLD_CYC);
  // Two-entry buffer depth
  localparam int SCD_BUF_DEPTH = 2;
endpackage : scd_pkg

// ---- hdl/scd_port.sv ----
// Serial port: clock rate, data buffer access and link timing
`timescale 1ns/1ps
// Notes on behaviour
// - Master clock is system clock over twice the sum of divider and one.
// - Divider only shapes the clock in master mode.
// - Data write loads transmit buffer and starts a master transfer.
// - Data read returns receive buffer contents.
// - Polarity one inverts the serial clock waveform.
// - Slave drives output within four periods of select fall, releases within four.
// - Slave updates output within four periods of shift edge.
// - With phase one, slave output holds at least six periods after last edge.
// - Slave samples mid-bit; master samples one period before bit end.
// - Completion flag sets at transfer end and stays until cleared.
// - Data write during transfer sets sticky collision flag.
module scd_port
  import scd_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic srst, // Sync reset, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data
  input wire logic port_enable, // Port enabled
  input wire logic master_mode, // 1 master, 0 slave
  input wire logic clock_polarity_select, // Idle clock level
  input wire logic clock_phase_select, // Second-edge sampling
  input wire logic transfer_complete_clr, // Clear completion flag
  input wire logic write_collision_clr, // Clear collision flag
  output logic transfer_complete_flag, // Sticky completion
  output logic write_collision_flag, // Sticky collision
  output logic busy, // Transfer in progress
  output logic sck_o, // Serial clock out
  output logic sck_oe, // Serial clock drive
  input wire logic sck_i, // Serial clock in
  output logic mosi_o, // Master data out
  output logic mosi_oe, // Master data drive
  input wire logic mosi_i, // Slave data in
  output logic miso_o, // Slave data out
  output logic miso_oe, // Slave data drive
  input wire logic miso_i, // Master data in
  input wire logic slave_select_line_n // Slave select, low active
);
  // ==========================================================
  // States
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_TAIL = 2'b10
  } scd_state_type;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
    addr_hit = (a == r);
  endfunction : addr_hit

  scd_state_type st_q, st_d;
  logic [7:0] div_q, div_d, rx_q, rx_d, sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic [3:0] tail_q, tail_d;
  logic phase_q, phase_d, mout_q, mout_d, soe_q, soe_d;
  logic tc_q, tc_d, wc_q, wc_d, lead_q, lead_d;
  logic [1:0] sck_s_q, ss_s_q;
  logic sck_p_q, sck_p_d, ss_p_q;
  logic wr_data, wr_div, half_tick, done;
  logic tx_valid, tx_ready, pop_tx;
  logic [7:0] tx_byte;
  logic sck_rise, sck_fall, lead_edge, trail_edge, sel;
  logic samp_edge, shift_edge;

  // ==========================================================
  // Register decode
  assign wr_data = reg_wr && addr_hit(reg_addr, SCD_ADDR_DATA);
  assign wr_div = reg_wr && addr_hit(reg_addr, SCD_ADDR_DIVIDER);

  // data read shows receive buffer; unmapped read as zero
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_rd && addr_hit(reg_addr, SCD_ADDR_DIVIDER)) begin
      reg_rdata = div_q;
    end else if (reg_rd && addr_hit(reg_addr, SCD_ADDR_DATA)) begin
      reg_rdata = rx_q;
    end
  end

  // write loads transmit buffer; stall refuses the byte
  scd_buf u_txbuf (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(wr_data && port_enable && !busy),
    .in_ready(tx_ready),
    .in_data(reg_wdata),
    .out_valid(tx_valid),
    .out_ready(pop_tx),
    .out_data(tx_byte)
  );

  // divider only runs the clock as master
  scd_rate u_rate (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(master_mode && st_q == ST_RUN),
    .clock_divider_value(div_q),
    .half_tick(half_tick)
  );

  // ==========================================================
  // Slave-side two-stage samplers; only stage two is read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sck_s_q <= 2'b00;
      ss_s_q <= 2'b11;
      ss_p_q <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[0], sck_i};
      ss_s_q <= {ss_s_q[0], slave_select_line_n};
      ss_p_q <= ss_s_q[1];
    end
  end

  // polarity one inverts clock for edge decoding
  assign sck_p_d = sck_s_q[1] ^ clock_polarity_select;
  assign sck_rise = sck_p_d && !sck_p_q;
  assign sck_fall = !sck_p_d && sck_p_q;
  assign sel = !ss_s_q[1];
  assign lead_edge = master_mode ? (half_tick && !phase_q) : (sel && sck_rise);
  assign trail_edge = master_mode ? (half_tick && phase_q) : (sel && sck_fall);
  // sample on first edge for phase 0, second for phase 1
  assign samp_edge = clock_phase_select ? trail_edge : lead_edge;
  assign shift_edge = clock_phase_select ? lead_edge : trail_edge;
  // Slave loads only on a fresh select fall, so a lingering select after a frame keeps the next byte
  assign pop_tx = (st_q == ST_IDLE) && tx_valid && port_enable
    && (master_mode || (sel && ss_p_q));
  assign done = (st_q == ST_RUN) && samp_edge == 1'b0 && shift_edge
    && (bit_q == SCD_LAST_BIT) && !clock_phase_select
    || (st_q == ST_RUN) && samp_edge && (bit_q == SCD_LAST_BIT) && clock_phase_select;
  assign busy = (st_q != ST_IDLE);

  // ==========================================================
  // Transfer engine next state
  always_comb begin
    st_d = st_q;
    div_d = wr_div ? reg_wdata : div_q;
    rx_d = rx_q;
    sh_d = sh_q;
    bit_d = bit_q;
    tail_d = tail_q;
    phase_d = phase_q;
    mout_d = mout_q;
    lead_d = lead_q;
    soe_d = sel && !master_mode && port_enable;
    // write during transfer; set wins over clear
    wc_d = (wr_data && busy) ? 1'b1 : (write_collision_clr ? 1'b0 : wc_q);
    // sticky completion; set wins over clear
    tc_d = (st_q == ST_TAIL && tail_q == 4'h0) ? 1'b1
      : (transfer_complete_clr ? 1'b0 : tc_q);
    case (st_q)
      ST_IDLE: begin
        phase_d = 1'b0;
        if (pop_tx) begin
          st_d = ST_RUN;
          sh_d = tx_byte;
          bit_d = 3'h0;
          mout_d = tx_byte[7];
          lead_d = 1'b0;
        end
      end
      ST_RUN: begin
        if (master_mode && half_tick) begin
          // each half lasts divider plus one periods
          phase_d = ~phase_q;
        end
        if (samp_edge) begin
          // master samples at tick, one period before bit end
          sh_d = {sh_q[6:0], master_mode ? miso_i : mosi_i};
          lead_d = 1'b1;
        end
        if (shift_edge && (lead_q || samp_edge)) begin
          // output follows shift edge within three periods
          mout_d = sh_d[7];
          bit_d = bit_q + 3'h1;
        end
        if (done) begin
          rx_d = sh_d;
          st_d = ST_TAIL;
          // phase one slave holds six periods after last edge
          tail_d = (clock_phase_select && !master_mode) ? SLV_LAST_HOLD_CNT : 4'h0;
        end
        if (!master_mode && !sel) begin
          st_d = ST_IDLE;
        end
      end
      ST_TAIL: begin
        if (tail_q != 4'h0) begin
          tail_d = tail_q - 4'h1;
        end else begin
          st_d = ST_IDLE;
          phase_d = 1'b0;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Register engine state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      div_q <= SCD_DIVIDER_RESET;
      rx_q <= SCD_DATA_RESET;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      tail_q <= 4'h0;
      phase_q <= 1'b0;
      mout_q <= 1'b0;
      lead_q <= 1'b0;
      soe_q <= 1'b0;
      tc_q <= 1'b0;
      wc_q <= 1'b0;
      sck_p_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      rx_q <= rx_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      tail_q <= tail_d;
      phase_q <= phase_d;
      mout_q <= mout_d;
      lead_q <= lead_d;
      soe_q <= soe_d;
      tc_q <= tc_d;
      wc_q <= wc_d;
      sck_p_q <= sck_p_d;
    end
  end

  // ==========================================================
  // Pins
  // master clock idles at polarity level
  assign sck_o = phase_q ^ clock_polarity_select;
  assign sck_oe = master_mode && port_enable;
  assign mosi_o = mout_q;
  assign mosi_oe = master_mode && port_enable;
  // slave drive follows select within four periods
  assign miso_o = mout_q;
  assign miso_oe = soe_q;
  assign transfer_complete_flag = tc_q;
  assign write_collision_flag = wc_q;
endmodule : scd_port

// ---- hdl/scd_rate.sv ----
// Master serial clock rate generator
`timescale 1ns/1ps
module scd_rate
  import scd_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic srst, // Sync reset
  input wire logic run, // Count while high
  input wire logic [7:0] clock_divider_value, // Half period minus one
  output logic half_tick // Pulse each half period
);
  // ==========================================================
  // Half-period counter
  logic [7:0] cnt_q, cnt_d;

  // divide by twice the sum of value and one
  always_comb begin
    cnt_d = cnt_q;
    half_tick = 1'b0;
    if (!run) begin
      cnt_d = 8'h00;
    end else if (cnt_q >= clock_divider_value) begin
      cnt_d = 8'h00;
      half_tick = 1'b1;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // Register count
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : scd_rate

// ---- testbench/scd_port_assertions.sv ----
// Checker on the serial port pins and flags
`timescale 1ns/1ps
module scd_port_chk
  import scd_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic srst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic [7:0] reg_wdata, // Data
  input wire logic port_enable, // Enable
  input wire logic master_mode, // Role
  input wire logic transfer_complete_clr, // Clear
  input wire logic write_collision_clr, // Clear
  input wire logic transfer_complete_flag, // Done
  input wire logic write_collision_flag, // Collision
  input wire logic busy, // Busy
  input wire logic sck_o, // Clock out
  input wire logic sck_oe, // Clock drive
  input wire logic miso_oe, // Data drive
  input wire logic slave_select_line_n // Select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [7:0] div_q;
  logic [8:0] cnt_q;
  logic sck_q;
  logic seen_q;
  logic tog;
  assign tog = sck_o != sck_q;
  // ====================
  // Half period tracker; assumes divider writes only while idle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_q <= SCD_DIVIDER_RESET;
      cnt_q <= 9'h000;
      seen_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == SCD_ADDR_DIVIDER) div_q <= reg_wdata;
      cnt_q <= tog ? 9'h000 : cnt_q + 9'h001;
      seen_q <= busy && (seen_q || tog);
    end
    sck_q <= sck_o;
  end
  // ====================
  // Assertions
  chk_clock_drive_role: assert property (sck_oe == (master_mode && port_enable))
    else $error("clock drive wrong for role");
  chk_half_period_len: assert property (busy && seen_q && tog |-> cnt_q == {1'b0, div_q})
    else $error("half period length wrong");
  chk_collision_set: assert property (
    busy && reg_wr && reg_addr == SCD_ADDR_DATA |=> write_collision_flag)
    else $error("collision flag not set");
  chk_collision_hold: assert property (
    write_collision_flag && !write_collision_clr |=> write_collision_flag)
    else $error("collision flag dropped");
  chk_done_hold: assert property (
    transfer_complete_flag && !transfer_complete_clr |=> transfer_complete_flag)
    else $error("done flag dropped");
  chk_done_at_end: assert property ($fell(busy) |-> ##[0:2] transfer_complete_flag)
    else $error("done flag missing");
  chk_miso_release: assert property ($rose(slave_select_line_n) |-> ##[0:4] !miso_oe)
    else $error("data line not released");
  chk_miso_drive_on: assert property (
    port_enable && !master_mode && $fell(slave_select_line_n) |-> ##[0:4] miso_oe)
    else $error("data line not driven");
  cover property ($rose(transfer_complete_flag));
  cover property ($rose(write_collision_flag));
  cover property ($rose(miso_oe));
endmodule : scd_port_chk
bind scd_port scd_port_chk u_chk (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .port_enable(port_enable), .master_mode(master_mode), .busy(busy), .sck_o(sck_o),
  .transfer_complete_clr(transfer_complete_clr), .write_collision_clr(write_collision_clr),
  .transfer_complete_flag(transfer_complete_flag), .write_collision_flag(write_collision_flag),
  .sck_oe(sck_oe), .miso_oe(miso_oe), .slave_select_line_n(slave_select_line_n)
);

// ---- testbench/scd_port_tb.sv ----
// Self-checking bench for the serial port
`timescale 1ns/1ps
module scd_port_tb;
  import scd_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tc_clr = 1'b0, wc_clr = 1'b0;
  logic port_enable = 1'b1, master_mode = 1'b1, cpol = 1'b0, cpha = 1'b0, sel = 1'b0;
  logic sck_i = 1'b0, mosi_i = 1'b0, ssn = 1'b1, sck_last = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tx_byte = 8'h00, reg_rdata, rx_byte, div, d, got;
  logic tc_flag, wc_flag, busy, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_i;
  int mismatches = 0, checks_done = 0, seed = 32'hdd70, cyc = 0, ntog = 0, tfirst = 0, tlast = 0;
  logic [7:0] txq[$];
  scd_port DUT (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_enable(port_enable),
    .master_mode(master_mode), .clock_polarity_select(cpol), .clock_phase_select(cpha),
    .transfer_complete_clr(tc_clr), .write_collision_clr(wc_clr), .busy(busy),
    .transfer_complete_flag(tc_flag), .write_collision_flag(wc_flag), .sck_o(sck_o),
    .sck_oe(sck_oe), .sck_i(sck_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .mosi_i(mosi_i),
    .miso_o(miso_o), .miso_oe(miso_oe), .miso_i(miso_i), .slave_select_line_n(ssn)
  );
  scd_slave_model u_slave (
    .sel(sel), .cpol(cpol), .cpha(cpha), .tx_byte(tx_byte), .sck(sck_o), .mosi(mosi_o),
    .miso(miso_i), .rx_byte(rx_byte)
  );
  always #25 ref_clk = ~ref_clk;
  // Serial clock toggle monitor, away from the launching edge
  always @(negedge ref_clk) begin
    cyc++;
    if (sck_o !== sck_last) begin
      ntog++;
      tlast = cyc;
      if (ntog == 1) tfirst = cyc;
    end
    sck_last = sck_o;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(negedge ref_clk);
    check(what, reg_rdata, exp);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
  endtask : rd
  task automatic clr_flags;
    @(posedge ref_clk);
    tc_clr <= 1'b1;
    wc_clr <= 1'b1;
    @(posedge ref_clk);
    tc_clr <= 1'b0;
    wc_clr <= 1'b0;
    @(negedge ref_clk);
    check("flags", {tc_flag, wc_flag}, 2'b00);
  endtask : clr_flags
  task automatic wait_idle;
    repeat (9000) if (busy !== 1'b0) @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
    check("idle", busy, 1'b0);
  endtask : wait_idle
  // Bench acts as external master; six-cycle phases leave margin on setup and hold
  // select gaps, phase lengths
  task automatic xfer(input logic [7:0] mo, output logic [7:0] mi);
    @(posedge ref_clk);
    ssn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check("out driven", miso_oe, 1'b1);
    // first half level follows phase and polarity
    for (int b = 7; b >= 0; b--) begin
      @(posedge ref_clk);
      sck_i <= cpha ^ cpol;
      mosi_i <= mo[b];
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      mi[b] = miso_o;
      @(posedge ref_clk);
      sck_i <= ~(cpha ^ cpol);
      repeat (5) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    sck_i <= cpol;
    mosi_i <= ~mo[0];
    repeat (4) @(posedge ref_clk);
    ssn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check("out released", miso_oe, 1'b0);
  endtask : xfer
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // Watchdog, several times the expected run length
  initial begin
    repeat (25000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    rd(SCD_ADDR_DIVIDER, SCD_DIVIDER_RESET, "divider reset");
    rd(SCD_ADDR_DATA, SCD_DATA_RESET, "data reset");
    rd(8'ha4, 8'h00, "unmapped");
    // Master role over all clock modes, last one at the slowest rate
    for (int i = 0; i < 5; i++) begin
      div = (i == 4) ? 8'hff : 8'($random(seed) & 3);
      d = 8'($random(seed));
      @(posedge ref_clk);
      cpol <= i[0];
      cpha <= i[1];
      tx_byte <= 8'($random(seed));
      wr(SCD_ADDR_DIVIDER, div);
      rd(SCD_ADDR_DIVIDER, div, "divider");
      check("idle level", sck_o, cpol);
      @(posedge ref_clk);
      sel <= 1'b1;
      ntog = 0;
      wr(SCD_ADDR_DATA, d);
      wr(SCD_ADDR_DATA, ~d);
      check("collision", wc_flag, 1'b1);
      wait_idle();
      check("toggles", ntog, 16);
      check("span", tlast - tfirst, 15 * (div + 1));
      check("sent", rx_byte, d);
      check("done", tc_flag, 1'b1);
      rd(SCD_ADDR_DATA, tx_byte, "received");
      clr_flags();
      @(posedge ref_clk);
      sel <= 1'b0;
    end
    // Slave role: buffer takes two bytes and drops the third
    @(posedge ref_clk);
    master_mode <= 1'b0;
    repeat (3) begin
      d = 8'($random(seed));
      wr(SCD_ADDR_DATA, d);
      if (txq.size() < SCD_BUF_DEPTH) txq.push_back(d);
    end
    check("no collision", wc_flag, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      cpol <= k[0];
      cpha <= k[0];
      sck_i <= k[0];
      repeat (4) @(posedge ref_clk);
      d = 8'($random(seed));
      xfer(d, got);
      check("slave sent", got, txq.pop_front());
      check("slave done", tc_flag, 1'b1);
      rd(SCD_ADDR_DATA, d, "slave received");
      clr_flags();
    end
    finish_test();
  end
endmodule : scd_port_tb

// ---- testbench/scd_slave_model.sv ----
// Behavioural external slave answering the port in master role
`timescale 1ns/1ps
module scd_slave_model (
  input wire logic sel, // Frame active
  input wire logic cpol, // Idle clock level
  input wire logic cpha, // Second-edge sampling
  input wire logic [7:0] tx_byte, // Byte to return
  input wire logic sck, // Serial clock
  input wire logic mosi, // Data in
  output logic miso, // Data out
  output logic [7:0] rx_byte // Byte captured
);
  logic [8:0] sr = 9'h000;
  logic out_b;
  // Load at frame start
  always @(posedge sel) begin
    sr = {1'b0, tx_byte};
    rx_byte = 8'h00;
  end
  always @(sck) begin
    if (sel && ((sck !== cpol) != cpha)) rx_byte = {rx_byte[6:0], mosi};
    else if (sel) sr = {sr[7:0], 1'b0};
  end
  // Released line shows the inverse so stale data never passes
  assign out_b = cpha ? sr[8] : sr[7];
  assign miso = sel ? out_b : ~out_b;
endmodule : scd_slave_model
